/* File: rtl/sara_consts.vh */
/*
 * constants for the serial address register access block: widths,
 * reset values and access codes.
 * assumes inclusion by bare name from rtl files only.
 */
`ifndef SARA_CONSTS_VH
`define SARA_CONSTS_VH
// ==========================================================
// widths and reset values
`define SARA_ADDR_W 10
`define SARA_MCAST_RST 10'h3ff
`define SARA_UCAST_RST 10'h000
`define SARA_NARROW_MASK 10'h0ff
`define SARA_PIN_IDLE 7'h7f
`define SARA_OE_ON 10'h3ff
`define SARA_OE_OFF 10'h000
// ==========================================================
// access codes on the direction and mode pins
`define SARA_DIR_WRITE 1'b0
`define SARA_DIR_READ 1'b1
`define SARA_MODE_MCAST 1'b0
`define SARA_MODE_UCAST 1'b1
// ==========================================================
// discard policy with filtering disabled
`define SARA_POLICY_NONE 2'h0
`endif

/* File: rtl/sara_sync2.v */
/*
 * two-flop synchroniser for a bundle of pin levels.
 * assumes pins are asynchronous to ref_clk_in.
 */
`timescale 1ns/10ps
module sara_sync2 #(
	parameter W = 1
) (
	input wire ref_clk_in,
	input wire srst_in,
	input wire [W-1:0] rst_val_in,
	input wire [W-1:0] pin_in,
	output reg [W-1:0] sync_out
);
	reg [W-1:0] meta_r;
	// ==========================================================
	// synchroniser flops; first stage is read only by the second
	always @(posedge ref_clk_in) begin
		if (srst_in) begin
			meta_r <= rst_val_in;
			sync_out <= rst_val_in;
		end else begin
			meta_r <= pin_in;
			sync_out <= meta_r;
		end
	end
endmodule // sara_sync2

/* File: rtl/sara_top.v */
/*
 * serial address register: host access over the receive parallel bus
 * and the address filter that gates receive fifo writes.
 * assumes a decoded character stream with a strobe on the same clock;
 * host pins are asynchronous and are synchronised here.
 */
`timescale 1ns/10ps
`include "sara_consts.vh"
module sara_top (
	input wire ref_clk_in,
	input wire srst_in,
	input wire device_select_n_in,
	input wire rx_fifo_clear_n_in,
	input wire rx_violation_flag_pin_in,
	input wire rx_special_char_select_in,
	input wire rx_output_enable_n_in,
	input wire fifo_bypass_n_in,
	input wire char_width8_in,
	input wire [1:0] discard_policy_in,
	input wire [9:0] receive_parallel_bus_in,
	output reg [9:0] receive_parallel_bus_out,
	output reg [9:0] receive_parallel_bus_oe_out,
	input wire rx_char_valid_in,
	input wire rx_char_is_addr_in,
	input wire [9:0] rx_char_in,
	output wire rx_fifo_write_out,
	output wire [9:0] mcast_addr_out,
	output wire [9:0] ucast_addr_out
);
	// ==========================================================
	// pin synchronisation
	wire [6:0] pins_s;
	wire [9:0] bus_s;
	wire sel_n_s;
	wire clr_n_s;
	wire dir_s;
	wire mode_s;
	wire oe_n_s;
	wire byp_n_s;
	wire w8_s;
	sara_sync2 #(.W(7)) u_sync_ctl (
		.ref_clk_in(ref_clk_in),
		.srst_in(srst_in),
		.rst_val_in(`SARA_PIN_IDLE),
		.pin_in({device_select_n_in,
			rx_fifo_clear_n_in,
			rx_violation_flag_pin_in,
			rx_special_char_select_in,
			rx_output_enable_n_in,
			fifo_bypass_n_in,
			char_width8_in}),
		.sync_out(pins_s)
	);
	// bus data shares the strobes' two-flop delay, so skew is not absorbed: write fires in the first cycle the access is seen
	sara_sync2 #(.W(10)) u_sync_bus (
		.ref_clk_in(ref_clk_in),
		.srst_in(srst_in),
		.rst_val_in(10'h000),
		.pin_in(receive_parallel_bus_in),
		.sync_out(bus_s)
	);
	assign sel_n_s = pins_s[6];
	assign clr_n_s = pins_s[5];
	assign dir_s = pins_s[4];
	assign mode_s = pins_s[3];
	assign oe_n_s = pins_s[2];
	assign byp_n_s = pins_s[1];
	assign w8_s = pins_s[0];

	// ==========================================================
	// access timing, in ref_clk_in edges after the host pins settle
	// edge 1: first flop takes the raw pin levels
	// edge 2: synchronised levels reach the decode below
	// edge 3: write lands in the selected register
	// edge 3: read data and enables appear on the bus outputs
	// the host must set direction, mode and bus before selecting:
	// a mode change inside an access comes too late to retarget the write
	// bus data is synchronised bit by bit, so it must be steady
	// for two edges before the access is seen, or a torn value lands
	// one write per access; the host must deselect to write again
	// read data follows the register, so a write seen on the same
	// cycle as a read shows up on the bus one edge later

	// narrow characters keep the upper two lines at zero
	function [9:0] sara_fit;
		input [9:0] v;
		input narrow;
		begin
			sara_fit = narrow ? (v & `SARA_NARROW_MASK) : v;
		end
	endfunction

	// ==========================================================
	// access decode
	wire access_w;
	wire wr_w;
	wire rd_w;
	assign access_w = ~sel_n_s & ~clr_n_s & ~oe_n_s;
	assign wr_w = access_w & (dir_s == `SARA_DIR_WRITE);
	assign rd_w = access_w & (dir_s == `SARA_DIR_READ);

	// write fires once per access, in the first cycle the access is seen
	reg wr_seen_r;
	reg [9:0] mcast_r;
	reg [9:0] ucast_r;
	reg [9:0] mcast_nxt;
	reg [9:0] ucast_nxt;
	wire wr_fire_w;
	assign wr_fire_w = wr_w & ~wr_seen_r;

	// ==========================================================
	// register write path
	always @* begin
		mcast_nxt = mcast_r;
		ucast_nxt = ucast_r;
		if (wr_fire_w) begin
			if (mode_s == `SARA_MODE_MCAST) begin
				mcast_nxt = sara_fit(bus_s, w8_s);
			end else begin
				ucast_nxt = sara_fit(bus_s, w8_s);
			end
		end
	end

	// reset leaves the filter promiscuous while characters are ten bits wide
	always @(posedge ref_clk_in) begin
		if (srst_in) begin
			mcast_r <= `SARA_MCAST_RST;
			ucast_r <= `SARA_UCAST_RST;
			wr_seen_r <= 1'b0;
		end else begin
			mcast_r <= mcast_nxt;
			ucast_r <= ucast_nxt;
			wr_seen_r <= wr_w;
		end
	end
	assign mcast_addr_out = mcast_r;
	assign ucast_addr_out = ucast_r;

	// ==========================================================
	// read path: registered data and enables on the bus
	reg [9:0] rd_data_nxt;
	always @* begin
		rd_data_nxt = (mode_s == `SARA_MODE_MCAST) ? mcast_r : ucast_r;
		rd_data_nxt = sara_fit(rd_data_nxt, w8_s);
	end
	always @(posedge ref_clk_in) begin
		if (srst_in) begin
			receive_parallel_bus_out <= 10'h000;
			receive_parallel_bus_oe_out <= `SARA_OE_OFF;
		end else begin
			receive_parallel_bus_out <= rd_w ? rd_data_nxt : 10'h000;
			receive_parallel_bus_oe_out <= rd_w ? `SARA_OE_ON : `SARA_OE_OFF;
		end
	end

	// ==========================================================
	// address filter
	// off: fifo bypassed, policy 0, or multicast at all ones
	// on: each address character re-judges the pass state
	// data characters follow the last address decision
	// limitation: a unicast value of zero cannot be matched,
	// since zero marks the unicast register as unused
	wire [9:0] ch_w;
	wire [9:0] dom_hit_w;
	wire promisc_w;
	wire mcast_hit_w;
	wire ucast_hit_w;
	wire filter_on_w;
	assign ch_w = sara_fit(rx_char_in, w8_s);
	assign promisc_w = (mcast_r == sara_fit(`SARA_MCAST_RST, w8_s));
	// one domain per register bit
	genvar gi;
	generate
		for (gi = 0; gi < 10; gi = gi + 1) begin : g_dom
			assign dom_hit_w[gi] = ch_w[gi] & mcast_r[gi];
		end
	endgenerate
	assign mcast_hit_w = |dom_hit_w;
	assign ucast_hit_w = (ch_w == ucast_r);
	// filtering needs fifo enabled and a policy other than 0
	assign filter_on_w = byp_n_s & (discard_policy_in != `SARA_POLICY_NONE)
		& ~promisc_w;

	reg pass_r;
	wire hit_w;
	// a domain bit hit or, when programmed, a unicast match passes
	assign hit_w = mcast_hit_w | (ucast_r != `SARA_UCAST_RST ? ucast_hit_w : 1'b0);
	always @(posedge ref_clk_in) begin
		if (srst_in) begin
			pass_r <= 1'b1;
		end else if (rx_char_valid_in & rx_char_is_addr_in) begin
			pass_r <= hit_w;
		end
	end
	// an address character is judged by its own match in the same cycle
	assign rx_fifo_write_out = rx_char_valid_in & (~filter_on_w
		| (rx_char_is_addr_in ? hit_w : pass_r));
endmodule // sara_top

/* File: testbench/sara_chk_checker.sv */
/* checker on sara_top ports
 assumes each host access is held at least four cycles */
`timescale 1ns/10ps
module sara_chk (
	input wire ref_clk_in,
	input wire srst_in,
	input wire device_select_n_in,
	input wire rx_fifo_clear_n_in,
	input wire rx_violation_flag_pin_in,
	input wire rx_special_char_select_in,
	input wire rx_output_enable_n_in,
	input wire fifo_bypass_n_in,
	input wire [1:0] discard_policy_in,
	input wire rx_char_valid_in,
	input wire rx_fifo_write_out,
	input wire [9:0] receive_parallel_bus_in,
	input wire [9:0] receive_parallel_bus_out,
	input wire [9:0] receive_parallel_bus_oe_out,
	input wire [9:0] mcast_addr_out,
	input wire [9:0] ucast_addr_out
);
// ==========
// raw pin decode; four samples cover the two sync flops
default clocking @(posedge ref_clk_in); endclocking
default disable iff (srst_in);
wire acc = !device_select_n_in && !rx_fifo_clear_n_in && !rx_output_enable_n_in;
wire rd = acc && rx_violation_flag_pin_in;
wire wm = acc && !rx_violation_flag_pin_in;
wire uc = rx_special_char_select_in;
a_mcast_reset: assert property ($fell(srst_in) |-> mcast_addr_out == 10'h3ff)
	else $error("mcast reset");
a_read_drive: assert property (rd [*4] |-> receive_parallel_bus_oe_out == 10'h3ff)
	else $error("read oe");
a_idle_float: assert property (!acc [*4] |-> receive_parallel_bus_oe_out == 10'h000)
	else $error("idle oe");
a_read_value: assert property ((rd && !uc) [*4] |-> receive_parallel_bus_out == mcast_addr_out)
	else $error("read data");
a_write_value: assert property ((wm && !uc) [*4] |-> mcast_addr_out[7:0] == receive_parallel_bus_in[7:0])
	else $error("write data");
a_mode_split: assert property ((wm && uc) [*4] |-> $stable(mcast_addr_out))
	else $error("mode split");
a_ucast_write: assert property ((wm && uc) [*4] |-> ucast_addr_out == receive_parallel_bus_in)
	else $error("unicast write");
a_bypass_open: assert property ((!fifo_bypass_n_in) [*3] ##0 rx_char_valid_in |-> rx_fifo_write_out)
	else $error("bypass");
a_policy_open: assert property (rx_char_valid_in && discard_policy_in == 2'h0 |-> rx_fifo_write_out)
	else $error("policy");
endmodule // sara_chk
bind sara_top sara_chk sara_chk_inst (.*);

/* File: testbench/sara_hm.sv */
/* host model for the access pins
 assumes calls start on a falling edge */
`timescale 1ns/10ps
module sara_hm (
	input wire ref_clk_in,
	output logic device_select_n_in = 1'b1,
	output logic rx_fifo_clear_n_in = 1'b1,
	output logic rx_output_enable_n_in = 1'b1,
	output logic rx_violation_flag_pin_in = 1'b0,
	output logic rx_special_char_select_in = 1'b0,
	output logic [9:0] receive_parallel_bus_in = 10'h000
);
// ==========
// set up first, then select; bus inverted after so stale data looks wrong
task automatic acc(input logic r, m, input logic [9:0] d);
	{rx_violation_flag_pin_in, rx_special_char_select_in} = {r, m};
	receive_parallel_bus_in = d;
	repeat (3) @(negedge ref_clk_in);
	{device_select_n_in, rx_fifo_clear_n_in, rx_output_enable_n_in} = 3'h0;
	repeat (6) @(negedge ref_clk_in);
	{device_select_n_in, rx_fifo_clear_n_in, rx_output_enable_n_in} = 3'h7;
	repeat (4) @(negedge ref_clk_in);
	receive_parallel_bus_in = ~d;
	@(negedge ref_clk_in);
endtask
endmodule // sara_hm

/* File: testbench/test_sara_top.sv */
/* bench for sara_top
 assumes the host model on the access pins */
`timescale 1ns/10ps
module test_sara_top;
logic ref_clk_in = 0, srst_in = 1, fifo_bypass_n_in = 1, char_width8_in = 0, o = 0;
logic rx_char_valid_in = 0, rx_char_is_addr_in = 0;
logic [1:0] discard_policy_in = 2'h1;
logic [9:0] rx_char_in = 10'h000, v, q[$];
wire device_select_n_in, rx_fifo_clear_n_in, rx_violation_flag_pin_in, rx_fifo_write_out;
wire rx_special_char_select_in, rx_output_enable_n_in;
wire [9:0] receive_parallel_bus_in, receive_parallel_bus_out, receive_parallel_bus_oe_out;
wire [9:0] mcast_addr_out, ucast_addr_out;
int err_total = 0, cmp_count = 0;
sara_top sara_top_inst (.*);
sara_hm sara_hm_inst (.*);
// ==========
// clock, watchdog, and watcher taking the oldest note
initial forever #2.5 ref_clk_in = ~ref_clk_in;
initial begin
	#20000 err_total++;
	results;
end
always @(posedge ref_clk_in) begin
	o <= receive_parallel_bus_oe_out[0];
	if (receive_parallel_bus_oe_out[0] === 1'b1 && o !== 1'b1) chk_rd(receive_parallel_bus_out);
	if (rx_char_valid_in) chk_wr(rx_fifo_write_out);
end
task automatic chk_wr(input logic a);
	logic [9:0] e;
	e = q.pop_front();
	cmp_count++;
	if ({9'h000, a} !== e) begin
		err_total++;
		$display("[FAIL] %0t %h %h", $time, a, e);
	end
endtask
task automatic chk_rd(input logic [9:0] a);
	logic [9:0] e;
	e = q.pop_front();
	cmp_count++;
	if (a !== e) begin
		err_total++;
		$display("[FAIL] %0t %h %h", $time, a, e);
	end
endtask
task automatic results;
	if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
	else $display("[ FAIL ]");
	$finish;
endtask
task automatic rd(input logic m, input logic [9:0] e);
	q.push_back(e);
	sara_hm_inst.acc(1, m, ~e);
endtask
task automatic ch(input logic a, input logic [9:0] c, input logic e);
	{rx_char_valid_in, rx_char_is_addr_in, rx_char_in} = {1'b1, a, c};
	q.push_back({9'h0, e});
	@(negedge ref_clk_in);
	rx_char_valid_in = 0;
	@(negedge ref_clk_in);
endtask
// ==========
// main sequence
initial begin
	v = 10'($urandom(32'h0705be2d));
	repeat (16) @(negedge ref_clk_in);
	srst_in = 0;
	rd(0, 10'h3ff);
	rd(1, 10'h000);
	sara_hm_inst.acc(0, 0, v);
	rd(0, v);
	sara_hm_inst.acc(0, 1, ~v);
	rd(1, ~v);
	char_width8_in = 1;
	sara_hm_inst.acc(0, 0, v);
	rd(0, v & 10'h0ff);
	char_width8_in = 0;
	sara_hm_inst.acc(0, 0, 10'h001);
	sara_hm_inst.acc(0, 1, 10'h200);
	ch(1, 10'h002, 0);
	ch(0, v, 0);
	ch(1, 10'h200, 1);
	ch(1, 10'h003, 1);
	ch(0, v, 1);
	ch(1, 10'h002, 0);
	discard_policy_in = 2'h0;
	ch(0, v, 1);
	discard_policy_in = 2'h2;
	fifo_bypass_n_in = 0;
	repeat (3) @(negedge ref_clk_in);
	ch(0, v, 1);
	results;
end
endmodule // test_sara_top
